// ==== rtl/gfl_cycle_avg.sv ====
// Discharge-cycle average tracker: running and previous-cycle averages
`timescale 1ns/1ps
`default_nettype none
module gfl_cycle_avg (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sample_valid_i,
  input wire logic discharging_i,
  input wire logic [15:0] sample_i,
  output logic [15:0] running_o,
  output logic [15:0] last_o
);

  logic [31:0] sum_reg;
  logic [15:0] count_reg;

  function automatic logic [15:0] avg(input logic [31:0] s,
                                      input logic [15:0] c);
    avg = (c == 16'h0000) ? 16'h0000 : 16'(s / {16'h0000, c});
  endfunction : avg

  // ----------------------------------------------------------------
  // Accumulation
  // ----------------------------------------------------------------
  // cycle average record
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sum_reg <= 32'h0;
      count_reg <= 16'h0;
      running_o <= 16'h0;
      last_o <= 16'h0;
    end
    else if (sample_valid_i && discharging_i)
    begin
      sum_reg <= sum_reg + {16'h0000, sample_i};
      count_reg <= count_reg + 16'h0001;
      running_o <= avg(sum_reg + {16'h0000, sample_i}, count_reg + 16'h0001);
    end
    else if (sample_valid_i && count_reg != 16'h0000)
    begin
      // Cycle over: keep its average for the next one
      last_o <= avg(sum_reg, count_reg);
      sum_reg <= 32'h0;
      count_reg <= 16'h0;
    end
  end

endmodule : gfl_cycle_avg
`default_nettype wire

// ==== rtl/gfl_gauge.sv ====
// Gauge flags, state-of-charge report and load model rate selection
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Remaining charge follows the signed charge integrated each update.
// - Low-capacity flag sets when remaining charge falls below its level.
// - Low-capacity flag clears only when charge rises above that level.
// - Battery-low pin mirrors the low-capacity flag one clock later.
// - The pin shows the flag only while the pin enable bit is set.
// - Voltage under shutdown set level sets warning flag, pulses pin.
// - Set warning flag clears above clear level, pulsing the pin.
// - Reported state of charge is zero at or below final voltage.
// - Status word always shows the configured load model.
// - Average discharge over each cycle is kept with previous cycle's.
// - Sources 0 and 1 pick previous or present cycle average.
// - Sources 2 and 3 pick averaged current or its filtered form.
// - Sources 4, 5, 6 pick capacity/5, host rate, user current rate.
// - In power model sources 4, 5, 6 use energy/5, host and user 10 mW rates.
module gfl_gauge (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_valid_i,
  input wire gfl_pkg::gfl_meas_t meas_i,
  output logic battery_low_pin_o,
  output logic charge_int_pin_o,
  output logic irq_o,
  output logic [15:0] soc_o,
  output logic [15:0] rate_o
);

  logic load_mode_reg;
  logic [2:0] rate_src_reg;
  logic low_flag_pin_enable_reg;
  logic [15:0] low_capacity_set_level_reg;
  logic [15:0] shutdown_set_level_reg;
  logic [15:0] shutdown_clear_level_reg;
  logic [15:0] final_v_reg;
  logic [15:0] host_rate_value_reg;
  logic [15:0] user_current_rate_reg;
  logic [15:0] user_power_rate_reg;
  logic [15:0] design_cap_reg;
  logic [15:0] design_nrg_reg;
  logic [3:0] int_status_reg;
  logic [3:0] int_mask_reg;
  logic [15:0] remaining_charge_value_reg;
  logic [15:0] volt_reg;
  logic [15:0] dsg_cur_reg;
  logic [15:0] dsg_pwr_reg;
  logic discharging_reg;
  logic upd_reg;
  logic low_capacity_flag_reg;
  logic shutdown_warning_flag_reg;
  logic [3:0] event_next;
  logic [15:0] pulse_cnt_reg;
  logic [15:0] avg_cur_run, avg_cur_last, avg_pwr_run, avg_pwr_last;
  logic [15:0] cur_filt;
  logic [15:0] rate_next;
  logic [31:0] rd_next;
  logic rd_ok;
  logic acc_phase, wr_en;

  function automatic logic [15:0] to_pwr(input logic [15:0] cur_ma,
                                         input logic [15:0] v_mv);
    to_pwr = 16'(({16'h0000, cur_ma} * {16'h0000, v_mv}) /
                  32'(gfl_pkg::POWER_DIV));
  endfunction : to_pwr

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: data and pready both come from flops
  assign acc_phase = psel && penable;
  assign wr_en = acc_phase && pready && pwrite;

  always_comb
  begin
    rd_ok = 1'b1;
    rd_next = 32'h0;
    case (paddr)
      gfl_pkg::OFS_CTRL: rd_next = {27'h0, low_flag_pin_enable_reg,
                                    rate_src_reg, load_mode_reg};
      gfl_pkg::OFS_STATUS: rd_next = {29'h0, load_mode_reg,
                                      shutdown_warning_flag_reg,
                                      low_capacity_flag_reg};
      gfl_pkg::OFS_LOW_SET: rd_next = {16'h0, low_capacity_set_level_reg};
      gfl_pkg::OFS_SD_SET: rd_next = {16'h0, shutdown_set_level_reg};
      gfl_pkg::OFS_SD_CLR: rd_next = {16'h0, shutdown_clear_level_reg};
      gfl_pkg::OFS_FINAL_V: rd_next = {16'h0, final_v_reg};
      gfl_pkg::OFS_HOST_RATE: rd_next = {16'h0, host_rate_value_reg};
      gfl_pkg::OFS_USER_CUR: rd_next = {16'h0, user_current_rate_reg};
      gfl_pkg::OFS_USER_PWR: rd_next = {16'h0, user_power_rate_reg};
      gfl_pkg::OFS_DESIGN_CAP: rd_next = {16'h0, design_cap_reg};
      gfl_pkg::OFS_DESIGN_NRG: rd_next = {16'h0, design_nrg_reg};
      gfl_pkg::OFS_SOC: rd_next = {16'h0, soc_o};
      gfl_pkg::OFS_RATE: rd_next = {16'h0, rate_o};
      gfl_pkg::OFS_LAST_AVG: rd_next = {avg_pwr_last, avg_cur_last};
      gfl_pkg::OFS_INT_STATUS: rd_next = {28'h0, int_status_reg};
      gfl_pkg::OFS_INT_MASK: rd_next = {28'h0, int_mask_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= acc_phase && !pready;
      pslverr <= acc_phase && !pready && !rd_ok;
      prdata <= (acc_phase && !pready && !pwrite) ? rd_next : 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      load_mode_reg <= 1'b0;
      rate_src_reg <= gfl_pkg::SRC_RESET;
      low_flag_pin_enable_reg <= 1'b0;
      low_capacity_set_level_reg <= gfl_pkg::LOW_SET_RESET;
      shutdown_set_level_reg <= gfl_pkg::SD_SET_RESET;
      shutdown_clear_level_reg <= gfl_pkg::SD_CLR_RESET;
      final_v_reg <= gfl_pkg::FINAL_V_RESET;
      host_rate_value_reg <= 16'h0;
      user_current_rate_reg <= 16'h0;
      user_power_rate_reg <= 16'h0;
      design_cap_reg <= gfl_pkg::DESIGN_CAP_RESET;
      design_nrg_reg <= gfl_pkg::DESIGN_NRG_RESET;
      int_mask_reg <= 4'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        gfl_pkg::OFS_CTRL:
        begin
          load_mode_reg <= pwdata[gfl_pkg::CTRL_MODE_BIT];
          rate_src_reg <= pwdata[gfl_pkg::CTRL_SRC_LSB +: 3];
          low_flag_pin_enable_reg <= pwdata[gfl_pkg::CTRL_PIN_EN_BIT];
        end
        gfl_pkg::OFS_LOW_SET: low_capacity_set_level_reg <= pwdata[15:0];
        gfl_pkg::OFS_SD_SET: shutdown_set_level_reg <= pwdata[15:0];
        gfl_pkg::OFS_SD_CLR: shutdown_clear_level_reg <= pwdata[15:0];
        gfl_pkg::OFS_FINAL_V: final_v_reg <= pwdata[15:0];
        gfl_pkg::OFS_HOST_RATE: host_rate_value_reg <= pwdata[15:0];
        gfl_pkg::OFS_USER_CUR: user_current_rate_reg <= pwdata[15:0];
        gfl_pkg::OFS_USER_PWR: user_power_rate_reg <= pwdata[15:0];
        gfl_pkg::OFS_DESIGN_CAP: design_cap_reg <= pwdata[15:0];
        gfl_pkg::OFS_DESIGN_NRG: design_nrg_reg <= pwdata[15:0];
        gfl_pkg::OFS_INT_MASK: int_mask_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Measurement capture and charge integration
  // ----------------------------------------------------------------
  // integrate passed charge
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      remaining_charge_value_reg <= 16'h0;
      volt_reg <= 16'h0;
      dsg_cur_reg <= 16'h0;
      dsg_pwr_reg <= 16'h0;
      discharging_reg <= 1'b0;
      upd_reg <= 1'b0;
    end
    else
    begin
      upd_reg <= meas_valid_i;
      if (meas_valid_i)
      begin
        // Saturate rather than wrap at empty or full
        if ($signed({1'b0, remaining_charge_value_reg}) +
            $signed({meas_i.charge_delta[15], meas_i.charge_delta}) < 0)
          remaining_charge_value_reg <= 16'h0;
        else if ($signed({1'b0, remaining_charge_value_reg}) +
                 $signed({meas_i.charge_delta[15], meas_i.charge_delta})
                 > $signed(17'h0ffff))
          remaining_charge_value_reg <= 16'hffff;
        else
          remaining_charge_value_reg <= remaining_charge_value_reg +
                                        meas_i.charge_delta;
        volt_reg <= meas_i.voltage_mv;
        discharging_reg <= meas_i.current_ma < 0;
        dsg_cur_reg <= (meas_i.current_ma < 0) ? 16'(-meas_i.current_ma)
                                               : 16'h0;
        dsg_pwr_reg <= (meas_i.current_ma < 0) ?
                       to_pwr(16'(-meas_i.current_ma), meas_i.voltage_mv)
                       : 16'h0;
      end
    end
  end

  gfl_cycle_avg u_cur_avg (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sample_valid_i(upd_reg),
    .discharging_i(discharging_reg),
    .sample_i(dsg_cur_reg),
    .running_o(avg_cur_run),
    .last_o(avg_cur_last)
  );

  gfl_cycle_avg u_pwr_avg (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sample_valid_i(upd_reg),
    .discharging_i(discharging_reg),
    .sample_i(dsg_pwr_reg),
    .running_o(avg_pwr_run),
    .last_o(avg_pwr_last)
  );

  gfl_lowpass u_lpf (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sample_valid_i(upd_reg),
    .sample_i(dsg_cur_reg),
    .filt_o(cur_filt)
  );

  // ----------------------------------------------------------------
  // Flags, pins and events
  // ----------------------------------------------------------------
  always_comb
  begin
    event_next = 4'h0;
    if (upd_reg)
    begin
      event_next[gfl_pkg::EV_LOW_SET] = !low_capacity_flag_reg &&
        remaining_charge_value_reg < low_capacity_set_level_reg;
      event_next[gfl_pkg::EV_LOW_CLR] = low_capacity_flag_reg &&
        remaining_charge_value_reg > low_capacity_set_level_reg;
      event_next[gfl_pkg::EV_SD_SET] = !shutdown_warning_flag_reg &&
        volt_reg < shutdown_set_level_reg;
      event_next[gfl_pkg::EV_SD_CLR] = shutdown_warning_flag_reg &&
        volt_reg > shutdown_clear_level_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      low_capacity_flag_reg <= 1'b0;
      shutdown_warning_flag_reg <= 1'b0;
    end
    else
    begin
      if (event_next[gfl_pkg::EV_LOW_SET])
        low_capacity_flag_reg <= 1'b1;
      else if (event_next[gfl_pkg::EV_LOW_CLR])
        low_capacity_flag_reg <= 1'b0;
      if (event_next[gfl_pkg::EV_SD_SET])
        shutdown_warning_flag_reg <= 1'b1;
      else if (event_next[gfl_pkg::EV_SD_CLR])
        shutdown_warning_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      battery_low_pin_o <= 1'b0;
    else
      battery_low_pin_o <= low_capacity_flag_reg && low_flag_pin_enable_reg;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pulse_cnt_reg <= 16'h0;
      charge_int_pin_o <= 1'b0;
    end
    else if (event_next[gfl_pkg::EV_SD_SET] ||
             event_next[gfl_pkg::EV_SD_CLR])
    begin
      pulse_cnt_reg <= 16'(gfl_pkg::INT_PULSE_CYC - 1);
      charge_int_pin_o <= 1'b1;
    end
    else
    begin
      charge_int_pin_o <= pulse_cnt_reg != 16'h0;
      if (pulse_cnt_reg != 16'h0)
        pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      int_status_reg <= 4'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      int_status_reg <= (int_status_reg &
        ~((wr_en && paddr == gfl_pkg::OFS_INT_STATUS) ? pwdata[3:0] : 4'h0))
        | event_next;
      irq_o <= |(int_status_reg & int_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // State of charge report and load rate
  // ----------------------------------------------------------------
  always_comb
  begin
    rate_next = 16'h0;
    case (rate_src_reg)
      3'h0: rate_next = load_mode_reg ? avg_pwr_last : avg_cur_last;
      3'h1: rate_next = load_mode_reg ? avg_pwr_run : avg_cur_run;
      3'h2: rate_next = load_mode_reg ? to_pwr(dsg_cur_reg, volt_reg)
                                      : dsg_cur_reg;
      3'h3: rate_next = load_mode_reg ? to_pwr(cur_filt, volt_reg)
                                      : cur_filt;
      3'h4: rate_next = (load_mode_reg ? design_nrg_reg : design_cap_reg) /
                        16'(gfl_pkg::CRATE_DIV);
      3'h5: rate_next = host_rate_value_reg;
      3'h6: rate_next = load_mode_reg ? user_power_rate_reg
                                      : user_current_rate_reg;
      default: rate_next = 16'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      soc_o <= 16'h0;
      rate_o <= 16'h0;
    end
    else
    begin
      soc_o <= (volt_reg <= final_v_reg) ? 16'h0
                                         : remaining_charge_value_reg;
      rate_o <= rate_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_CHARGE_SUM: assert property (
    meas_valid_i && meas_i.charge_delta >= 0 &&
    remaining_charge_value_reg < 16'h8000 && meas_i.charge_delta < 16'sh4000
    |=> remaining_charge_value_reg ==
        $past(remaining_charge_value_reg) + $past(meas_i.charge_delta))
    else $error("Charge not integrated");
  AST_LOW_SET: assert property (
    upd_reg && remaining_charge_value_reg < low_capacity_set_level_reg
    |=> low_capacity_flag_reg ##1 (!low_flag_pin_enable_reg ||
                                   battery_low_pin_o))
    else $error("Low flag not set");
  AST_LOW_HOLD: assert property (
    low_capacity_flag_reg && !(upd_reg &&
      remaining_charge_value_reg > low_capacity_set_level_reg)
    |=> low_capacity_flag_reg)
    else $error("Low flag cleared early");
  AST_PIN_GATE: assert property (
    !low_flag_pin_enable_reg |=> !battery_low_pin_o)
    else $error("Pin driven while disabled");
  AST_SD_SET: assert property (
    upd_reg && !shutdown_warning_flag_reg && volt_reg < shutdown_set_level_reg
    |=> shutdown_warning_flag_reg && charge_int_pin_o)
    else $error("Shutdown set not signalled");
  AST_SD_CLR: assert property (
    upd_reg && shutdown_warning_flag_reg &&
    volt_reg > shutdown_clear_level_reg
    |=> !shutdown_warning_flag_reg && charge_int_pin_o)
    else $error("Shutdown clear not signalled");
  AST_SOC_ZERO: assert property (
    volt_reg <= final_v_reg |=> soc_o == 16'h0)
    else $error("State of charge not forced to zero");
  AST_LOAD_MODEL_STATUS_BIT_READ: assert property (
    acc_phase && pready && !pwrite && paddr == gfl_pkg::OFS_STATUS
    |-> prdata[gfl_pkg::ST_LOAD_MODEL_STATUS_BIT_BIT] == load_mode_reg)
    else $error("Load model bit wrong");
  AST_HOST_RATE: assert property (
    rate_src_reg == 3'h5 |=> rate_o == $past(host_rate_value_reg))
    else $error("Host rate not selected");
  AST_PULSE_WIDTH: assert property (
    $rose(charge_int_pin_o) |-> charge_int_pin_o [*8])
    else $error("Interrupt pulse too short");

  COV_LOW_FLAG: cover property ($rose(low_capacity_flag_reg));
  COV_SD_CYCLE: cover property ($fell(shutdown_warning_flag_reg));
  COV_POWER_SRC: cover property (load_mode_reg && rate_src_reg == 3'h3);
  COV_IRQ: cover property ($rose(irq_o));

endmodule : gfl_gauge
`default_nettype wire

// ==== rtl/gfl_lowpass.sv ====
// First-order low-pass filter on the averaged current
`timescale 1ns/1ps
`default_nettype none
module gfl_lowpass (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  output logic [15:0] filt_o
);

  // Extra fraction bits keep the shift's stall short of a rising input under one output step
  logic [23:0] acc_reg;
  logic [23:0] diff;

  always_comb
  begin
    diff = {sample_i, 8'h00} - acc_reg;
  end

  // ----------------------------------------------------------------
  // Filter step
  // ----------------------------------------------------------------
  // time constant filter
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      acc_reg <= 24'h0;
    else if (sample_valid_i)
      acc_reg <= acc_reg + 24'($signed(diff) >>> gfl_pkg::LPF_SHIFT);
  end

  assign filt_o = acc_reg[23:8];

endmodule : gfl_lowpass
`default_nettype wire

// ==== rtl/gfl_pkg.sv ====
// Constants, layouts and carriers for the gauge flag and load model block
package gfl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int INT_PULSE_US = 10;
  localparam int INT_PULSE_CYC = (INT_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int LPF_TAU_S = 14;
  localparam int UPDATE_PERIOD_S = 1;
  localparam int LPF_SHIFT = $clog2(LPF_TAU_S / UPDATE_PERIOD_S);
  localparam int POWER_DIV = 10000;
  localparam int CRATE_DIV = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LOW_SET = 8'h08;
  localparam logic [7:0] OFS_SD_SET = 8'h0c;
  localparam logic [7:0] OFS_SD_CLR = 8'h10;
  localparam logic [7:0] OFS_FINAL_V = 8'h14;
  localparam logic [7:0] OFS_HOST_RATE = 8'h18;
  localparam logic [7:0] OFS_USER_CUR = 8'h1c;
  localparam logic [7:0] OFS_USER_PWR = 8'h20;
  localparam logic [7:0] OFS_DESIGN_CAP = 8'h24;
  localparam logic [7:0] OFS_DESIGN_NRG = 8'h28;
  localparam logic [7:0] OFS_SOC = 8'h2c;
  localparam logic [7:0] OFS_RATE = 8'h30;
  localparam logic [7:0] OFS_LAST_AVG = 8'h34;
  localparam logic [7:0] OFS_INT_STATUS = 8'h38;
  localparam logic [7:0] OFS_INT_MASK = 8'h3c;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_PIN_EN_BIT = 4;
  localparam int ST_LOW_BIT = 0;
  localparam int ST_SD_BIT = 1;
  localparam int ST_LOAD_MODEL_STATUS_BIT_BIT = 2;
  localparam int EV_LOW_SET = 0;
  localparam int EV_LOW_CLR = 1;
  localparam int EV_SD_SET = 2;
  localparam int EV_SD_CLR = 3;
  localparam logic [2:0] SRC_RESET = 3'h1;
  localparam logic [15:0] LOW_SET_RESET = 16'h0096;
  localparam logic [15:0] SD_SET_RESET = 16'h0c80;
  localparam logic [15:0] SD_CLR_RESET = 16'h0d48;
  localparam logic [15:0] FINAL_V_RESET = 16'h0bb8;
  localparam logic [15:0] DESIGN_CAP_RESET = 16'h03e8;
  localparam logic [15:0] DESIGN_NRG_RESET = 16'h0172;

  // Measurement carrier: one update per strobe
  typedef struct packed {
    logic signed [15:0] charge_delta;
    logic [15:0] voltage_mv;
    logic signed [15:0] current_ma;
  } gfl_meas_t;

endpackage : gfl_pkg

// ==== testbench/gfl_host_model.sv ====
// Host-side model that watches the charge-state interrupt pin
`timescale 1ns/1ps
`default_nettype none
module gfl_host_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic int_pin_i,
  output var int pulses_o,
  output var int width_o
);
  int run;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pulses_o <= 0;
      width_o <= 0;
      run <= 0;
    end
    else if (int_pin_i)
    begin
      run <= run + 1;
      if (run == 0)
        pulses_o <= pulses_o + 1;
    end
    else if (run != 0)
    begin
      width_o <= run;
      run <= 0;
    end
  end
endmodule : gfl_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the gauge flag and load model block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t %h vs %h", $time, a, b); end end
module tb_top;
  logic sys_clk_i = 0;
  logic reset_n_i = 0;
  logic psel = 0, penable = 0, pwrite = 0, meas_valid_i = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, bl_pin, int_pin, irq;
  logic [15:0] soc, rate, hr;
  gfl_pkg::gfl_meas_t meas_i = '0;
  int fails = 0, n_checks = 0, seed = 63, cyc = 0, rem = 0, pulses, width;
  // Discharge cycle bookkeeping for the average sources
  int sum_c = 0, cnt_c = 0, run_c = 0, last_c = 0, dsg_c = 0;
  logic signed [15:0] dl [6] = '{16'sh00c8, -16'sh0032, -16'sh0001,
    16'sh0001, 16'sh0001, -16'sh0002};
  logic pe [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  gfl_gauge i_gfl_gauge (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid_i(meas_valid_i), .meas_i(meas_i),
    .battery_low_pin_o(bl_pin), .charge_int_pin_o(int_pin), .irq_o(irq),
    .soc_o(soc), .rate_o(rate));
  gfl_host_model i_gfl_host_model (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .int_pin_i(int_pin), .pulses_o(pulses),
    .width_o(width));
  initial
  begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard: whole run needs far fewer cycles
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    // Only pready or the hang guard ends this wait
    do
    begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic meas(input logic signed [15:0] d, input logic [15:0] v);
    logic signed [15:0] cur;
    @(posedge sys_clk_i);
    cur = 16'($random(seed));
    meas_valid_i <= 1'b1;
    meas_i <= {d, v, cur};
    rem = rem + d;
    dsg_c = (cur < 0) ? -int'(cur) : 0;
    if (cur < 0)
    begin
      sum_c += dsg_c;
      cnt_c++;
      run_c = sum_c / cnt_c;
    end
    else if (cnt_c != 0)
    begin
      last_c = sum_c / cnt_c;
      sum_c = 0;
      cnt_c = 0;
    end
    @(posedge sys_clk_i);
    meas_valid_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    `CHK(soc, (v <= gfl_pkg::FINAL_V_RESET) ? 16'h0000 : 16'(rem))
  endtask : meas
  task automatic rt(input logic [31:0] c, input logic [15:0] e);
    apb(1'b1, 8'h00, c);
    repeat (4) @(posedge sys_clk_i);
    `CHK(rate, e)
  endtask : rt
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h3c, 32'h4);
    for (int i = 0; i < 6; i++)
    begin
      meas(dl[i], 16'h0e10);
      `CHK(bl_pin, pe[i])
    end
    // Pin gated off while the flag stays set
    apb(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    `CHK(bl_pin, 1'b0)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[0], 1'b1)
    $display("low capacity test done");
    meas(16'sh0033, 16'h0c1c);
    `CHK({pulses, irq}, {32'sd1, 1'b1})
    meas(16'sh0000, 16'h0ce4);
    `CHK(pulses, 1)
    repeat (100) @(posedge sys_clk_i);
    `CHK(width, gfl_pkg::INT_PULSE_CYC)
    apb(1'b1, 8'h38, 32'h4);
    repeat (3) @(posedge sys_clk_i);
    `CHK(irq, 1'b0)
    meas(16'sh0000, 16'h0dac);
    apb(1'b0, 8'h04, 32'h0);
    `CHK({pulses, rd[1]}, {32'sd2, 1'b0})
    // Let the clear pulse end so the next set shows as a new pulse
    repeat (100) @(posedge sys_clk_i);
    meas(-16'sh0005, 16'h0b54);
    `CHK(pulses, 3)
    $display("shutdown test done");
    hr = 16'($random(seed));
    apb(1'b1, 8'h18, {16'h0, hr});
    apb(1'b1, 8'h1c, {16'h0, hr ^ 16'h00ff});
    apb(1'b1, 8'h20, {16'h0, hr ^ 16'hff00});
    rt(32'h0, 16'(last_c));
    rt(32'h2, 16'(run_c));
    rt(32'h4, 16'(dsg_c));
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rd[15:0], 16'(last_c))
    rt(32'h8, 16'(gfl_pkg::DESIGN_CAP_RESET / gfl_pkg::CRATE_DIV));
    rt(32'h9, 16'(gfl_pkg::DESIGN_NRG_RESET / gfl_pkg::CRATE_DIV));
    rt(32'ha, hr);
    rt(32'hc, hr ^ 16'h00ff);
    rt(32'hb, hr);
    rt(32'hd, hr ^ 16'hff00);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[2], 1'b1)
    $display("load model test done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
